// File: core/pwm_pkg.sv
package pwm_pkg;
  // =====================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_TIMEBASE_COUNT = 8'h00; // timebase_count
  localparam logic [7:0] OFS_PERIOD_MATCH = 8'h04;   // timebase_period_match
  localparam logic [7:0] OFS_TIMEBASE_CTRL = 8'h08;  // timebase_control
  localparam logic [7:0] OFS_U1_DUTY_BYTE = 8'h0c;   // unit1_duty_byte
  localparam logic [7:0] OFS_U1_ACTIVE = 8'h10;      // unit1_active_duty
  localparam logic [7:0] OFS_U1_CONTROL = 8'h14;     // unit1_control
  localparam logic [7:0] OFS_U2_DUTY_BYTE = 8'h18;   // unit2_duty_byte
  localparam logic [7:0] OFS_U2_ACTIVE = 8'h1c;      // unit2_active_duty
  localparam logic [7:0] OFS_U2_CONTROL = 8'h20;     // unit2_control
  localparam logic [7:0] OFS_SHUTDOWN = 8'h24;       // shutdown_control
  localparam logic [7:0] OFS_DEADBAND = 8'h28;       // deadband_restart_control
  // =====================================================================
  // field positions
  localparam int TB_PRESCALE_LSB = 0;  // timebase_prescale_select <1:0>
  localparam int TB_RUN_BIT = 2;       // timebase_run
  localparam int TB_POSTSCALE_LSB = 3; // timebase_postscale_select <6:3>
  localparam int DUTY_LOW_LSB = 4;     // duty_low_bits <5:4>
  localparam int ENH_CFG_LSB = 6;      // enhanced_output_config <7:6>
  // =====================================================================
  // reset values and constants
  localparam logic [7:0] RST_BYTE = 8'h00;       // registers clear except period match
  localparam logic [7:0] PERIOD_RESET = 8'hff;   // period match after reset
  localparam logic [1:0] MODE_PWM_HI = 2'h3;     // mode<3:2>=11 selects pwm
  localparam logic [3:0] MODE_OFF = 4'h0;        // mode 0000 resets unit
  localparam logic [1:0] QUARTER_STEPS = 2'h3;   // 4 oscillator phases per tick
  localparam logic [7:0] U2_CTRL_MASK = 8'h3f;   // unit2 has no top two bits
  localparam logic [7:0] T2_CTRL_MASK = 8'h7f;   // timebase bit7 unimplemented
endpackage : pwm_pkg

// File: core/pwm_top.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// =====================================================================
module pwm_top
  import pwm_pkg::*;
#(
  parameter int ADDR_W = 8 // apb address width
)(
  input wire logic pclk,               // 125 MHz system clock
  input wire logic presetn,            // async reset, active low
  input wire logic psel,               // apb select
  input wire logic penable,            // apb access phase
  input wire logic pwrite,             // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata,      // apb write data
  output logic [31:0] prdata,          // apb read data, registered
  output logic pready,                 // apb ready, always one
  output logic pslverr,                // apb error on unmapped address
  input wire logic [1:0] pin_direction_bit_n, // per unit, low makes pin output
  input wire logic shutdown_in,        // external fault input for unit one
  output logic [1:0] pwm_output_pin_o,  // pin output level per unit
  output logic [1:0] pwm_output_pin_oe, // pin drive enable per unit
  output logic postscale_tick          // postscaled period pulse
);
  // =====================================================================
  // parameter check
  initial begin
    if (ADDR_W < 6) $error("address width too small for register map");
  end

  // =====================================================================
  // registers
  logic [7:0] count_ff;     // timebase_count
  logic [7:0] period_ff;    // timebase_period_match
  logic [7:0] tctrl_ff;     // timebase_control
  logic [7:0] duty1_ff;     // unit1_duty_byte
  logic [7:0] ctrl1_ff;     // unit1_control
  logic [7:0] duty2_ff;     // unit2_duty_byte
  logic [7:0] ctrl2_ff;     // unit2_control
  logic [7:0] shut_ff;      // shutdown_control
  logic [7:0] dead_ff;      // deadband_restart_control
  logic [1:0] q_ff;         // oscillator quarter phase
  logic [3:0] pre_ff;       // prescaler count
  logic [3:0] post_ff;      // postscaler count
  logic [1:0] fault_s1_ff;  // fault synchroniser stage one
  logic [1:0] fault_s2_ff;  // fault synchroniser stage two
  logic [1:0] dir_s1_ff;    // direction synchroniser stage one
  logic [1:0] dir_s2_ff;    // direction synchroniser stage two
  logic fault_sticky_ff;    // latched shutdown event
  logic [31:0] prdata_ff;   // registered read data
  logic [7:0] active1;      // unit1 active duty
  logic [7:0] active2;      // unit2 active duty
  logic [1:0] raw_out;      // unit outputs before shutdown

  // =====================================================================
  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire [7:0] addr8 = paddr[7:0];
  wire hit_count = (addr8 == OFS_TIMEBASE_COUNT);
  wire hit_period = (addr8 == OFS_PERIOD_MATCH);
  wire hit_tctrl = (addr8 == OFS_TIMEBASE_CTRL);
  wire hit_duty1 = (addr8 == OFS_U1_DUTY_BYTE);
  wire hit_act1 = (addr8 == OFS_U1_ACTIVE);
  wire hit_ctrl1 = (addr8 == OFS_U1_CONTROL);
  wire hit_duty2 = (addr8 == OFS_U2_DUTY_BYTE);
  wire hit_act2 = (addr8 == OFS_U2_ACTIVE);
  wire hit_ctrl2 = (addr8 == OFS_U2_CONTROL);
  wire hit_shut = (addr8 == OFS_SHUTDOWN);
  wire hit_dead = (addr8 == OFS_DEADBAND);
  wire hit_any = hit_count | hit_period | hit_tctrl | hit_duty1 | hit_act1 | hit_ctrl1
               | hit_duty2 | hit_act2 | hit_ctrl2 | hit_shut | hit_dead;
  wire high_zero = (paddr[ADDR_W-1:0] >> 8) == '0;
  wire mapped = hit_any && high_zero;
  // active latches are read-only in every mode; writes land nowhere
  wire wr_active = apb_wr && mapped && (hit_act1 || hit_act2);

  // =====================================================================
  // timebase
  function automatic logic [3:0] prescale_div(input logic [1:0] sel);
    // 00 -> 1, 01 -> 4, 1x -> 16, minus one for counting
    case (sel)
      2'h0: prescale_div = 4'h0;
      2'h1: prescale_div = 4'h3;
      default: prescale_div = 4'hf;
    endcase
  endfunction : prescale_div

  wire tb_run = tctrl_ff[TB_RUN_BIT];
  wire [1:0] pre_sel = tctrl_ff[TB_PRESCALE_LSB +: 2];
  wire [3:0] pre_max = prescale_div(pre_sel);
  // one pclk stands for one oscillator period; four form an increment
  wire pre_wrap = (pre_ff == pre_max);
  wire q_wrap = (q_ff == QUARTER_STEPS);
  wire tick = tb_run && pre_wrap && q_wrap;
  wire period_hit = (count_ff == period_ff);
  wire rollover = tick && period_hit;
  wire [3:0] post_max = tctrl_ff[TB_POSTSCALE_LSB +: 4];
  wire wr_count = apb_wr && mapped && hit_count;
  // quarter phase and prescaler advance only while running
  wire restart_pre = !tb_run || wr_count;
  wire [1:0] nxt_q = restart_pre ? 2'h0 : q_ff + 2'h1;
  wire [3:0] nxt_pre = (restart_pre || pre_sel == 2'h0 || (q_wrap && pre_wrap)) ? 4'h0 :
                       q_wrap ? pre_ff + 4'h1 : pre_ff;
  // counter clears on the increment after matching the period
  wire [7:0] nxt_count = wr_count ? pwdata[7:0] : rollover ? RST_BYTE :
                         tick ? count_ff + 8'h01 : count_ff;
  // sub bits step once per duty unit: quarter phase, prescaler lsbs or msbs
  wire [1:0] nxt_sub = (pre_sel == 2'h0) ? nxt_q :
                       (pre_sel == 2'h1) ? nxt_pre[1:0] : nxt_pre[3:2];
  // units compare the phase of the next edge, so the registered pin drops
  // exactly when the extended count reaches the duty, not a cycle late
  wire [9:0] nxt_phase = {nxt_count, nxt_sub};

  // timebase state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= 2'h0;
      pre_ff <= 4'h0;
      count_ff <= RST_BYTE;
    end else begin
      q_ff <= nxt_q;
      pre_ff <= nxt_pre;
      count_ff <= nxt_count;
    end
  end

  // postscaler only paces its own tick, never the pwm period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_ff <= 4'h0;
      postscale_tick <= 1'b0;
    end else begin
      postscale_tick <= rollover && (post_ff == post_max);
      if (rollover) begin
        post_ff <= (post_ff == post_max) ? 4'h0 : post_ff + 4'h1;
      end
    end
  end

  // =====================================================================
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff <= PERIOD_RESET;
      tctrl_ff <= RST_BYTE;
      duty1_ff <= RST_BYTE;
      ctrl1_ff <= RST_BYTE;
      duty2_ff <= RST_BYTE;
      ctrl2_ff <= RST_BYTE;
      shut_ff <= RST_BYTE;
      dead_ff <= RST_BYTE;
    end else if (apb_wr && mapped) begin
      if (hit_period) period_ff <= pwdata[7:0];
      if (hit_tctrl) tctrl_ff <= pwdata[7:0] & T2_CTRL_MASK;
      if (hit_duty1) duty1_ff <= pwdata[7:0];
      if (hit_ctrl1) ctrl1_ff <= pwdata[7:0];
      if (hit_duty2) duty2_ff <= pwdata[7:0];
      if (hit_ctrl2) ctrl2_ff <= pwdata[7:0] & U2_CTRL_MASK;
      if (hit_shut) shut_ff <= pwdata[7:0];
      if (hit_dead) dead_ff <= pwdata[7:0];
    end
  end

  // =====================================================================
  // pwm units
  pwm_unit u_unit1 (
    .pclk(pclk),
    .presetn(presetn),
    .duty_byte(duty1_ff),
    .duty_low(ctrl1_ff[DUTY_LOW_LSB +: 2]),
    .mode(ctrl1_ff[3:0]),
    .rollover(rollover),
    .phase(nxt_phase),
    .active_duty(active1),
    .pwm_out(raw_out[0])
  );
  pwm_unit u_unit2 (
    .pclk(pclk),
    .presetn(presetn),
    .duty_byte(duty2_ff),
    .duty_low(ctrl2_ff[DUTY_LOW_LSB +: 2]),
    .mode(ctrl2_ff[3:0]),
    .rollover(rollover),
    .phase(nxt_phase),
    .active_duty(active2),
    .pwm_out(raw_out[1])
  );

  // =====================================================================
  // shutdown, unit one only; pins pass two flip-flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_s1_ff <= 2'h0;
      fault_s2_ff <= 2'h0;
      dir_s1_ff <= 2'h3;
      dir_s2_ff <= 2'h3;
    end else begin
      fault_s1_ff <= {1'b0, shutdown_in};
      fault_s2_ff <= fault_s1_ff;
      dir_s1_ff <= pin_direction_bit_n;
      dir_s2_ff <= dir_s1_ff;
    end
  end
  wire shut_en = |shut_ff[6:4];
  // sticky until software clears bit 7; restart bit lets rollover clear
  wire fault_set = shut_en && fault_s2_ff[0];
  wire shut_clr = (apb_wr && mapped && hit_shut && !pwdata[7])
                || (dead_ff[7] && rollover && !fault_s2_ff[0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_sticky_ff <= 1'b0;
    end else if (fault_set) begin
      fault_sticky_ff <= 1'b1; // set beats clear
    end else if (shut_clr) begin
      fault_sticky_ff <= 1'b0;
    end
  end
  wire fault_active = fault_sticky_ff | shut_ff[7];
  // second unit never sees the shutdown term
  assign pwm_output_pin_o = {raw_out[1], raw_out[0] & !fault_active};
  assign pwm_output_pin_oe = ~dir_s2_ff;

  // =====================================================================
  // read path
  wire [7:0] rd_byte =
      hit_count ? count_ff :
      hit_period ? period_ff :
      hit_tctrl ? tctrl_ff :
      hit_duty1 ? duty1_ff :
      hit_act1 ? active1 :
      hit_ctrl1 ? ctrl1_ff :
      hit_duty2 ? duty2_ff :
      hit_act2 ? active2 :
      hit_ctrl2 ? ctrl2_ff :
      hit_shut ? {fault_active, shut_ff[6:0]} :
      hit_dead ? dead_ff : RST_BYTE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_ff <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // =====================================================================
  AST_ROLL_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (rollover && !wr_count) |=> count_ff == 8'h00) else $error("count not cleared");
  AST_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && pre_sel == 2'h1) |-> pre_ff == 4'h3) else $error("bad prescale step");
  AST_ACTIVE_RO: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_active && !rollover) |=> active1 == $past(active1)) else $error("active written");
  AST_U2_NOCFG: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl2_ff[7:6] == 2'h0) else $error("unit two top bits set");
  AST_POST: assert property (@(posedge pclk) disable iff (!presetn)
    postscale_tick |-> $past(rollover)) else $error("postscale tick off period");
  COV_ROLL: cover property (@(posedge pclk) disable iff (!presetn) rollover);
  COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) $rose(fault_active));
endmodule : pwm_top

// File: core/pwm_unit.sv
`timescale 1ns/1ns
// =====================================================================
// one pwm channel: double-buffered duty and compare against timebase
module pwm_unit
  import pwm_pkg::*;
(
  input wire logic pclk,               // system clock
  input wire logic presetn,            // async reset, active low
  input wire logic [7:0] duty_byte,    // software duty msbs
  input wire logic [1:0] duty_low,     // software duty lsbs
  input wire logic [3:0] mode,         // unit_mode_select
  input wire logic rollover,           // period boundary pulse
  input wire logic [9:0] phase,        // count extended by two sub bits
  output logic [7:0] active_duty,      // active_duty_latch
  output logic pwm_out                 // pwm_output_pin level
);
  // =====================================================================
  wire pwm_mode = (mode[3:2] == MODE_PWM_HI);
  wire unit_off = (mode == MODE_OFF);
  logic [1:0] hidden_low_ff;                   // hidden 2-bit latch
  logic [1:0] nxt_hidden_low;
  logic [7:0] nxt_active;
  logic out_ff;
  logic nxt_out;
  wire [9:0] active10 = {active_duty, hidden_low_ff};
  wire match = (active10 == phase);
  // copy buffers at rollover only, so mid-period writes never glitch
  assign nxt_active = rollover ? duty_byte : active_duty;
  assign nxt_hidden_low = rollover ? duty_low : hidden_low_ff;
  // set at period start unless new duty is zero; clear on compare match
  assign nxt_out = !pwm_mode ? 1'b0 :
                   rollover ? ({duty_byte, duty_low} != 10'h000) :
                   match ? 1'b0 : out_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_duty <= RST_BYTE;
      hidden_low_ff <= 2'h0;
      out_ff <= 1'b0;
    end else if (unit_off) begin
      active_duty <= RST_BYTE;
      hidden_low_ff <= 2'h0;
      out_ff <= 1'b0;
    end else begin
      active_duty <= nxt_active;
      hidden_low_ff <= nxt_hidden_low;
      out_ff <= nxt_out;
    end
  end
  assign pwm_out = out_ff;

  // =====================================================================
  AST_OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    $past(unit_off) |-> !pwm_out) else $error("unit off but output high");
  AST_ZERO_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
    (rollover && pwm_mode && !unit_off && {duty_byte, duty_low} == 10'h000) |=> !pwm_out)
    else $error("zero duty set output");
  AST_SET_START: assert property (@(posedge pclk) disable iff (!presetn)
    (rollover && pwm_mode && !unit_off && {duty_byte, duty_low} != 10'h000) |=> pwm_out)
    else $error("output not set at period start");
  AST_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (rollover && !unit_off) |=> active_duty == $past(duty_byte))
    else $error("duty not latched at rollover");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!rollover && !unit_off) |=> $stable(active_duty)) else $error("active duty moved");
  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (match && !rollover && !unit_off) |=> !pwm_out) else $error("no clear on match");
  COV_PULSE: cover property (@(posedge pclk) disable iff (!presetn) $fell(pwm_out));
  COV_SET: cover property (@(posedge pclk) disable iff (!presetn) $rose(pwm_out));
  COV_OFF: cover property (@(posedge pclk) disable iff (!presetn) unit_off ##1 !unit_off);
endmodule : pwm_unit

// File: tb/pwm_load_model.sv
`timescale 1ns/1ns
// =====================================================================
// external load on one pwm pin, with a pull-down to ground
module pwm_load_model (
  input wire logic pclk, // sampling clock
  input wire logic clr, // restart both counters
  input wire logic pin_o, // level the block drives
  input wire logic pin_oe, // block drives the pin
  output logic level, // resolved wire level
  output logic [15:0] high_cnt_ff, // cycles seen high
  output logic [15:0] rise_cnt_ff // rising edges seen
);
  logic prev_ff; // level one cycle back
  // a released pin falls to the pull-down, it never keeps the last value
  assign level = pin_oe ? pin_o : 1'b0;
  // =====================================================================
  // counters: a window of whole periods makes both exact whatever the phase
  always @(posedge pclk) begin
    prev_ff <= level;
    if (clr) begin
      high_cnt_ff <= 16'h0000;
      rise_cnt_ff <= 16'h0000;
    end else begin
      high_cnt_ff <= high_cnt_ff + {15'h0000, level};
      rise_cnt_ff <= rise_cnt_ff + {15'h0000, level & ~prev_ff};
    end
  end
endmodule : pwm_load_model

// File: tb/pwm_top_tb_top.sv
`timescale 1ns/1ns
// =====================================================================
// bench: apb register calls, waveforms measured by the load models
module timer_based_pwm_output_tb_top
  import pwm_pkg::*;
;
  logic pclk = 1'b0; // 125 MHz clock
  logic presetn = 1'b0; // reset, active low
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [7:0] paddr = 8'h00; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready; // apb ready
  logic pslverr; // apb error
  logic [1:0] dir_n = 2'h3; // pin direction, both inputs at first
  logic shutdown_in = 1'b0; // fault input of unit one
  logic [1:0] pin_o; // pin levels
  logic [1:0] pin_oe; // pin enables
  logic tick; // postscaled pulse
  logic clr = 1'b1; // load counter restart
  logic [1:0] level; // wire levels
  logic [15:0] high_cnt [2]; // high cycles per pin
  logic [15:0] rise_cnt [2]; // rising edges per pin
  logic [31:0] q; // last read data
  logic err; // last error flag
  int n_mismatch = 0; // mismatches
  int cmp_count = 0; // comparisons
  int cyc = 0; // elapsed cycles
  int f; // prescale factor

  always #4 pclk = ~pclk;

  pwm_top #(.ADDR_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_direction_bit_n(dir_n),
    .shutdown_in(shutdown_in), .pwm_output_pin_o(pin_o),
    .pwm_output_pin_oe(pin_oe), .postscale_tick(tick)
  );

  for (genvar i = 0; i < 2; i++) begin : g_load
    pwm_load_model load (
      .pclk(pclk), .clr(clr), .pin_o(pin_o[i]), .pin_oe(pin_oe[i]),
      .level(level[i]), .high_cnt_ff(high_cnt[i]), .rise_cnt_ff(rise_cnt[i])
    );
  end

  // =====================================================================
  // apb master: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never drives psel twice in a step
    @(posedge pclk);
  endtask : apb

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), q, exp);
  endtask : rdc

  // counts over n cycles; n is a whole number of periods
  task automatic meas(input int n, input logic [15:0] h0, r0, h1, r1);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge pclk);
    chk("pin0 high", {16'h0, high_cnt[0]}, {16'h0, h0});
    chk("pin0 rises", {16'h0, rise_cnt[0]}, {16'h0, r0});
    chk("pin1 high", {16'h0, high_cnt[1]}, {16'h0, h1});
    chk("pin1 rises", {16'h0, rise_cnt[1]}, {16'h0, r1});
  endtask : meas

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, the unmapped word, unimplemented bits
    for (int a = 0; a <= 'h28; a += 4) begin
      rdc(8'(a), (8'(a) == OFS_PERIOD_MATCH) ? {24'h0, PERIOD_RESET} : 32'h0);
    end
    wr(8'h2c, 32'h5a);
    chk("unmapped error", {31'h0, err}, 32'h1);
    rdc(8'h2c, 32'h0);
    wr(OFS_TIMEBASE_CTRL, 32'hfb);
    rdc(OFS_TIMEBASE_CTRL, 32'h7b);
    wr(OFS_TIMEBASE_COUNT, 32'h05);
    rdc(OFS_TIMEBASE_COUNT, 32'h05);
    wr(OFS_TIMEBASE_COUNT, 32'h00);
    chk("pin enable", {30'h0, pin_oe}, 32'h0);
    tend("registers");
    // setup in the recommended order; unit two duty beyond the period
    wr(OFS_PERIOD_MATCH, 32'h03);
    wr(OFS_U1_DUTY_BYTE, 32'h01);
    wr(OFS_U1_CONTROL, 32'h20);
    wr(OFS_U2_DUTY_BYTE, 32'h10);
    dir_n <= 2'h0;
    wr(OFS_TIMEBASE_CTRL, 32'h04);
    chk("pin enable", {30'h0, pin_oe}, 32'h3);
    wr(OFS_U1_CONTROL, 32'h2c);
    wr(OFS_U2_CONTROL, 32'h0c);
    repeat (40) @(posedge pclk);
    meas(160, 16'd60, 16'd10, 16'd160, 16'd0);
    tend("waveform");
    // active latch: loaded at rollover only, writes to it ignored
    rdc(OFS_U1_ACTIVE, 32'h01);
    wr(OFS_U1_ACTIVE, 32'h55);
    rdc(OFS_U1_ACTIVE, 32'h01);
    wr(OFS_TIMEBASE_CTRL, 32'h00);
    wr(OFS_U1_DUTY_BYTE, 32'h02);
    repeat (40) @(posedge pclk);
    rdc(OFS_U1_ACTIVE, 32'h01);
    wr(OFS_U1_DUTY_BYTE, 32'h01);
    tend("buffering");
    // every prescale code; the last one also sets the postscaler
    for (int p = 0; p < 4; p++) begin
      f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wr(OFS_TIMEBASE_CTRL, 32'h04 | 32'(p) | ((p == 3) ? 32'h78 : 32'h0));
      repeat (32 * f + 8) @(posedge pclk);
      meas(32 * f, 16'(12 * f), 16'd2, 16'(32 * f), 16'd0);
    end
    tend("prescale");
    // fault input shuts unit one only
    wr(OFS_TIMEBASE_CTRL, 32'h04);
    wr(OFS_SHUTDOWN, 32'h10);
    shutdown_in <= 1'b1;
    repeat (40) @(posedge pclk);
    rdc(OFS_SHUTDOWN, 32'h90);
    meas(160, 16'd0, 16'd0, 16'd160, 16'd0);
    shutdown_in <= 1'b0;
    // let the fault leave the synchroniser, else the set beats the clear
    repeat (4) @(posedge pclk);
    wr(OFS_SHUTDOWN, 32'h10);
    repeat (40) @(posedge pclk);
    meas(160, 16'd60, 16'd10, 16'd160, 16'd0);
    tend("shutdown");
    // unit off, zero duty, unit two control cleared
    wr(OFS_U1_CONTROL, 32'he0);
    rdc(OFS_U1_CONTROL, 32'he0);
    rdc(OFS_U1_ACTIVE, 32'h00);
    wr(OFS_U1_DUTY_BYTE, 32'h00);
    wr(OFS_U1_CONTROL, 32'h0c);
    wr(OFS_U2_CONTROL, 32'hc0);
    rdc(OFS_U2_CONTROL, 32'h00);
    repeat (40) @(posedge pclk);
    meas(160, 16'd0, 16'd0, 16'd0, 16'd0);
    tend("off");
    final_report();
  end
endmodule : timer_based_pwm_output_tb_top
